//--- core/flash_power_wait_control.sv
// flash_power_wait_control: bank and pump power sequencing, wait states,
// supply-low flag and option register.
// assumes one system clock, register port active only in config mode.
module flash_power_wait_control (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  // system state
  input  wire logic                 configMode,
  input  wire logic                 haltMode,
  input  wire logic                 supplyBelow,
  input  wire logic                 pumpCmd,
  // array access
  input  wire logic [3:0]           bankAccess,
  input  wire logic                 readReq,
  input  wire logic [1:0]           readBank,
  // register port
  input  wire logic                 regSel,
  input  wire logic                 regWr,
  input  wire logic                 regWord,
  input  wire logic [3:0]           regAddr,
  input  wire logic [31:0]          regWdata,
  output logic      [31:0]          regRdata,
  // status out
  output logic                      readReady,
  output logic      [3:0]           bankReady,
  output logic                      pumpActive,
  output logic                      supplyLowFlag,
  output logic                      pipelineActive,
  output logic                      otpReadEnable,
  output logic      [1:0]           marginMode
);

  localparam int NB = flash_pwr_pkg::NUM_BANKS;

  // register state
  logic [5:0]  opt_q,   opt_d;
  logic [1:0]  bsel_q,  bsel_d;
  logic [15:0] ac1_q [NB];
  logic [15:0] ac1_d [NB];
  logic [15:0] ac2_q [NB];
  logic [15:0] ac2_d [NB];
  logic [15:0] pcf_q,   pcf_d;
  // power state, supply filter and registered outputs
  logic [1:0]  bmode_q [NB];
  logic [1:0]  bmode_d [NB];
  logic [7:0]  bgrace_q [NB];
  logic [7:0]  bgrace_d [NB];
  logic [6:0]  bwait_q [NB];
  logic [6:0]  bwait_d [NB];
  logic [1:0]  pmode_q, pmode_d;
  logic [7:0]  pgrace_q, pgrace_d;
  logic [3:0]  pwait_q, pwait_d;
  logic [1:0]  lowCnt_q, lowCnt_d;
  logic        flag_q, flag_d;
  logic [31:0] rd_q, rd_d;
  logic        rdy_q, rdy_d;
  logic [3:0]  brdy_q, brdy_d;
  logic        pact_q, pact_d, pipe_q, pipe_d, otp_q, otp_d;
  logic [1:0]  mrg_q, mrg_d;

  function automatic logic wrHit(input logic [3:0] a);
    wrHit = regSel && regWr && configMode && regAddr == a;
  endfunction : wrHit

  logic anyBankUp;
  logic [3:0] bankRdyNow;

  // register file
  always_comb begin
    opt_d  = opt_q;
    bsel_d = bsel_q;
    pcf_d  = pcf_q;
    for (int i = 0; i < NB; i++) begin
      ac1_d[i] = ac1_q[i];
      ac2_d[i] = ac2_q[i];
    end
    if (wrHit(flash_pwr_pkg::OFS_OPTION) && regWord) begin
      opt_d = regWdata[5:0];
    end
    if (wrHit(flash_pwr_pkg::OFS_BANK_SEL)) begin
      bsel_d = regWdata[1:0];
    end
    if (wrHit(flash_pwr_pkg::OFS_BANK_AC1)) begin
      ac1_d[bsel_q] = regWdata[15:0];
    end
    if (wrHit(flash_pwr_pkg::OFS_BANK_AC2)) begin
      ac2_d[bsel_q] = regWdata[15:0];
    end
    if (wrHit(flash_pwr_pkg::OFS_PUMP_CFG)) begin
      pcf_d = regWdata[15:0];
    end
  end

  // bank power sequencing
  always_comb begin
    anyBankUp = 1'b0;
    for (int i = 0; i < NB; i++) begin
      bmode_d[i]  = bmode_q[i];
      bgrace_d[i] = bgrace_q[i];
      bwait_d[i]  = bwait_q[i];
      if (bankAccess[i]) begin
        bgrace_d[i] = ac1_q[i][flash_pwr_pkg::AC1_GRACE_LSB +: 8];
        if (bmode_q[i] != flash_pwr_pkg::PWR_ACTIVE) begin
          bmode_d[i] = flash_pwr_pkg::PWR_ACTIVE;
          bwait_d[i] = (bmode_q[i] == flash_pwr_pkg::PWR_SLEEP)
            ? ac2_q[i][flash_pwr_pkg::AC2_SLEEP_LSB +: 7]
            : {1'b0, ac1_q[i][flash_pwr_pkg::AC1_STBY_LSB +: 6]};
        end else if (bwait_q[i] != 7'h00) begin
          bwait_d[i] = bwait_q[i] - 7'h01;
        end
      end else begin
        // idle bank preloads its data-rate wait for the next access
        bwait_d[i] = {3'h0, ac2_q[i][flash_pwr_pkg::AC2_WAIT_LSB +: 4]};
        if (bgrace_q[i] != 8'h00) begin
          bgrace_d[i] = bgrace_q[i] - 8'h01;
        end else if (ac1_q[i][1:0] != flash_pwr_pkg::PWR_RSVD) begin
          bmode_d[i] = ac1_q[i][1:0];
        end
      end
      if (bmode_q[i] != flash_pwr_pkg::PWR_SLEEP || bankAccess[i]) begin
        anyBankUp = 1'b1;
      end
    end
  end

  // pump power sequencing
  always_comb begin
    pmode_d  = pmode_q;
    pgrace_d = pgrace_q;
    pwait_d  = (pwait_q != 4'h0) ? pwait_q - 4'h1 : 4'h0;
    if (anyBankUp || pumpCmd) begin
      pgrace_d = pcf_q[flash_pwr_pkg::PCF_GRACE_LSB +: 8];
      if (pmode_q == flash_pwr_pkg::PWR_SLEEP) begin
        pmode_d = flash_pwr_pkg::PWR_STANDBY;
        pwait_d = pcf_q[flash_pwr_pkg::PCF_SLEEP_LSB +: 4];
      end else if (pmode_q != flash_pwr_pkg::PWR_ACTIVE
                   && pwait_q == 4'h0) begin
        pmode_d = flash_pwr_pkg::PWR_ACTIVE;
        pwait_d = {2'h0, pcf_q[flash_pwr_pkg::PCF_STBY_LSB +: 2]};
      end
    end else if (pgrace_q != 8'h00) begin
      pgrace_d = pgrace_q - 8'h01;
    end else if (pcf_q[1:0] != flash_pwr_pkg::PWR_RSVD) begin
      pmode_d = pcf_q[1:0];
    end
  end

  // ready, supply flag, option outputs, read data
  always_comb begin
    for (int i = 0; i < NB; i++) begin
      bankRdyNow[i] = bmode_q[i] == flash_pwr_pkg::PWR_ACTIVE
        && pmode_q == flash_pwr_pkg::PWR_ACTIVE
        && bwait_q[i] == 7'h00 && pwait_q == 4'h0;
    end
    brdy_d = bankRdyNow;
    rdy_d  = readReq && bankRdyNow[readBank];
    pact_d = pmode_q == flash_pwr_pkg::PWR_ACTIVE;
    lowCnt_d = supplyBelow
      ? ((lowCnt_q == flash_pwr_pkg::SUPPLY_LOW_CLKS) ? lowCnt_q
         : lowCnt_q + 2'h1)
      : 2'h0;
    flag_d = supplyBelow
      && lowCnt_q == flash_pwr_pkg::SUPPLY_LOW_CLKS;
    pipe_d = opt_q[flash_pwr_pkg::OPT_PIPE_BIT]
      && !configMode && !haltMode;
    otp_d = opt_q[flash_pwr_pkg::OPT_OTP_BIT]
      && !opt_q[flash_pwr_pkg::OPT_RSVD_BIT];
    if (opt_q[flash_pwr_pkg::OPT_MRG0_BIT]) begin
      mrg_d = 2'h1;
    end else if (opt_q[flash_pwr_pkg::OPT_MRG1_BIT]) begin
      mrg_d = 2'h2;
    end else begin
      mrg_d = 2'h0;
    end
    rd_d = 32'h0000_0000;
    if (regSel && !regWr && configMode) begin
      unique case (regAddr)
        flash_pwr_pkg::OFS_OPTION:   rd_d = {26'h0, opt_q};
        flash_pwr_pkg::OFS_BANK_SEL: rd_d = {30'h0, bsel_q};
        flash_pwr_pkg::OFS_BANK_AC1: rd_d = {16'h0, ac1_q[bsel_q]};
        flash_pwr_pkg::OFS_BANK_AC2: rd_d = {16'h0, ac2_q[bsel_q]};
        flash_pwr_pkg::OFS_PUMP_CFG: rd_d = {16'h0, pcf_q};
        flash_pwr_pkg::OFS_STATUS:   rd_d = {22'h0, pact_q, 1'b0,
                                             brdy_q, 3'h0, flag_q};
        default:                     rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      opt_q    <= flash_pwr_pkg::OPT_RESET;
      bsel_q   <= 2'h0;
      pcf_q    <= flash_pwr_pkg::PCF_RESET;
      pmode_q  <= flash_pwr_pkg::PWR_ACTIVE;
      pgrace_q <= 8'h00;
      pwait_q  <= 4'h0;
      lowCnt_q <= 2'h0;
      flag_q   <= 1'b0;
      rd_q     <= 32'h0000_0000;
      rdy_q    <= 1'b0;
      brdy_q   <= 4'h0;
      pact_q   <= 1'b0;
      pipe_q   <= 1'b0;
      otp_q    <= 1'b0;
      mrg_q    <= 2'h0;
      for (int i = 0; i < NB; i++) begin
        ac1_q[i]    <= flash_pwr_pkg::AC1_RESET;
        ac2_q[i]    <= flash_pwr_pkg::AC2_RESET;
        bmode_q[i]  <= flash_pwr_pkg::PWR_ACTIVE;
        bgrace_q[i] <= 8'h00;
        bwait_q[i]  <= 7'h00;
      end
    end else begin
      opt_q    <= opt_d;
      bsel_q   <= bsel_d;
      pcf_q    <= pcf_d;
      pmode_q  <= pmode_d;
      pgrace_q <= pgrace_d;
      pwait_q  <= pwait_d;
      lowCnt_q <= lowCnt_d;
      flag_q   <= flag_d;
      rd_q     <= rd_d;
      rdy_q    <= rdy_d;
      brdy_q   <= brdy_d;
      pact_q   <= pact_d;
      pipe_q   <= pipe_d;
      otp_q    <= otp_d;
      mrg_q    <= mrg_d;
      for (int i = 0; i < NB; i++) begin
        ac1_q[i]    <= ac1_d[i];
        ac2_q[i]    <= ac2_d[i];
        bmode_q[i]  <= bmode_d[i];
        bgrace_q[i] <= bgrace_d[i];
        bwait_q[i]  <= bwait_d[i];
      end
    end
  end

  assign regRdata       = rd_q;
  assign readReady      = rdy_q;
  assign bankReady      = brdy_q;
  assign pumpActive     = pact_q;
  assign supplyLowFlag  = flag_q;
  assign pipelineActive = pipe_q;
  assign otpReadEnable  = otp_q;
  assign marginMode     = mrg_q;

  sequence s_lowFour;
    supplyBelow [*4];
  endsequence

  AST_SUPPLY: assert property (@(posedge ref_clk)
    disable iff (!rst_b) s_lowFour |=> supplyLowFlag)
    else $error("supply flag missing");
  AST_SUPPLY_CLR: assert property (@(posedge ref_clk)
    disable iff (!rst_b) !supplyBelow |=> !supplyLowFlag)
    else $error("flag stuck");
  AST_PIPE: assert property (@(posedge ref_clk)
    disable iff (!rst_b) configMode |=> !pipelineActive)
    else $error("pipe in config");
  AST_MARGIN: assert property (@(posedge ref_clk)
    disable iff (!rst_b) opt_q[2] |=> marginMode == 2'h1)
    else $error("margin order");
  AST_ACCESS: assert property (@(posedge ref_clk)
    disable iff (!rst_b) bankAccess[0] |=> bmode_q[0] == 2'b11)
    else $error("no wake");
  AST_RELOAD: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    bankAccess[0] |=> bgrace_q[0] == $past(ac1_q[0][15:8]))
    else $error("grace reload");
  AST_PUMPHOLD: assert property (@(posedge ref_clk)
    disable iff (!rst_b) anyBankUp |=> pgrace_q == $past(pcf_q[15:8]))
    else $error("pump grace ran");
  AST_PUMPSTEP: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    pmode_q == flash_pwr_pkg::PWR_SLEEP
      |=> pmode_q != flash_pwr_pkg::PWR_ACTIVE)
    else $error("pump skipped standby");
  AST_READY: assert property (@(posedge ref_clk)
    disable iff (!rst_b) bmode_q[0] != 2'b11 |=> !bankReady[0])
    else $error("early ready");
  AST_CFGREAD: assert property (@(posedge ref_clk)
    disable iff (!rst_b) !configMode |=> regRdata == 32'h0000_0000)
    else $error("read outside config");

endmodule : flash_power_wait_control

//--- pkg/flash_pwr_pkg.sv
// flash_pwr_pkg: constants shared by the flash power and wait control
// assumes a single system clock domain at 10 MHz
package flash_pwr_pkg;

  localparam int NUM_BANKS = 4;

  // power modes, two-bit fallback encoding
  typedef enum logic [1:0] {
    PWR_SLEEP   = 2'b00,
    PWR_STANDBY = 2'b01,
    PWR_RSVD    = 2'b10,
    PWR_ACTIVE  = 2'b11
  } pwr_mode_t;

  // register indices (word slots)
  localparam logic [3:0] OFS_OPTION   = 4'h0;
  localparam logic [3:0] OFS_BANK_SEL = 4'h1;
  localparam logic [3:0] OFS_BANK_AC1 = 4'h2;
  localparam logic [3:0] OFS_BANK_AC2 = 4'h3;
  localparam logic [3:0] OFS_PUMP_CFG = 4'h4;
  localparam logic [3:0] OFS_STATUS   = 4'h5;

  // option_control fields
  localparam int OPT_PIPE_BIT   = 0;
  localparam int OPT_OTP_BIT    = 1;
  localparam int OPT_MRG0_BIT   = 2;
  localparam int OPT_MRG1_BIT   = 3;
  localparam int OPT_RSVD_BIT   = 4;
  localparam int OPT_DPTEST_BIT = 5;
  localparam logic [5:0] OPT_RESET = 6'h00;

  // bank access control 1: grace[15:8] standby[7:2] fallback[1:0]
  localparam int AC1_GRACE_LSB = 8;
  localparam int AC1_STBY_LSB  = 2;
  localparam logic [15:0] AC1_RESET = 16'h0003;
  // bank access control 2: sleep[14:8] wait[7:4]
  localparam int AC2_SLEEP_LSB = 8;
  localparam int AC2_WAIT_LSB  = 4;
  localparam logic [15:0] AC2_RESET = 16'h0000;
  // pump config: grace[15:8] sleep[7:4] stby[3:2] fallback[1:0]
  localparam int PCF_GRACE_LSB = 8;
  localparam int PCF_SLEEP_LSB = 4;
  localparam int PCF_STBY_LSB  = 2;
  localparam logic [15:0] PCF_RESET = 16'h0003;

  // status: supply flag bit 0, pump ready bit 9, bank ready bits 7:4
  localparam int STS_SUPPLY_BIT = 0;
  localparam int STS_BRDY_LSB   = 4;
  localparam int STS_PRDY_BIT   = 9;

  // supply must read low for more than this many clocks
  localparam logic [1:0] SUPPLY_LOW_CLKS = 2'h3;

endpackage : flash_pwr_pkg

//--- verif/flash_power_wait_control_tb.sv
// flash_power_wait_control_tb: self-checking bench for power and wait control
// assumes host_model drives the register port, bench the rest
module flash_power_wait_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rst_b, configMode, haltMode, supplyBelow, pumpCmd;
  logic [3:0]  bankAccess;
  logic        readReq;
  logic [1:0]  readBank;
  logic        regSel, regWr, regWord;
  logic [3:0]  regAddr;
  logic [31:0] regWdata, regRdata, q;
  logic        readReady, pumpActive, supplyLowFlag;
  logic        pipelineActive, otpReadEnable;
  logic [3:0]  bankReady;
  logic [1:0]  marginMode;
  int          n_mismatch, n_tests;
  flash_power_wait_control dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .configMode(configMode), .haltMode(haltMode), .supplyBelow(supplyBelow),
    .pumpCmd(pumpCmd), .bankAccess(bankAccess), .readReq(readReq),
    .readBank(readBank), .regSel(regSel), .regWr(regWr), .regWord(regWord),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .readReady(readReady), .bankReady(bankReady), .pumpActive(pumpActive),
    .supplyLowFlag(supplyLowFlag), .pipelineActive(pipelineActive),
    .otpReadEnable(otpReadEnable), .marginMode(marginMode));
  host_model hm (.ref_clk(ref_clk), .regSel(regSel), .regWr(regWr),
    .regWord(regWord), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic print_verdict;
    $display("mismatches=%0d tests=%0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic t_reset;
    hm.access(flash_pwr_pkg::OFS_OPTION, 1'b0, 1'b1, '0, q);
    check(q, 32'h0000_0000);
    hm.access(flash_pwr_pkg::OFS_BANK_AC1, 1'b0, 1'b1, '0, q);
    check(q, 32'h0000_0003);
  endtask : t_reset
  task automatic t_option;
    hm.access(flash_pwr_pkg::OFS_OPTION, 1'b1, 1'b1, 32'h0000_000C, q);
    cyc(1);
    check(marginMode, 2'h1);
    hm.access(flash_pwr_pkg::OFS_OPTION, 1'b1, 1'b1, 32'h0000_0008, q);
    cyc(1);
    check(marginMode, 2'h2);
    hm.access(flash_pwr_pkg::OFS_OPTION, 1'b1, 1'b1, 32'h0000_0002, q);
    cyc(1);
    check(otpReadEnable, 1'b1);
    hm.access(flash_pwr_pkg::OFS_OPTION, 1'b1, 1'b0, 32'h0000_000C, q);
    hm.access(flash_pwr_pkg::OFS_OPTION, 1'b0, 1'b1, '0, q);
    check(q, 32'h0000_0002);
  endtask : t_option
  task automatic t_refuse;
    configMode = 1'b0;
    hm.access(flash_pwr_pkg::OFS_OPTION, 1'b0, 1'b1, '0, q);
    check(q, 32'h0000_0000);
    hm.access(flash_pwr_pkg::OFS_OPTION, 1'b1, 1'b1, 32'h0000_0008, q);
    configMode = 1'b1;
    hm.access(flash_pwr_pkg::OFS_OPTION, 1'b0, 1'b1, '0, q);
    check(q, 32'h0000_0002);
  endtask : t_refuse
  task automatic t_pipe;
    hm.access(flash_pwr_pkg::OFS_OPTION, 1'b1, 1'b1, 32'h0000_0001, q);
    cyc(2);
    check(pipelineActive, 1'b0);
    configMode = 1'b0;
    cyc(2);
    check(pipelineActive, 1'b1);
    haltMode = 1'b1;
    cyc(2);
    check(pipelineActive, 1'b0);
    haltMode   = 1'b0;
    configMode = 1'b1;
  endtask : t_pipe
  task automatic t_supply;
    supplyBelow = 1'b1;
    cyc(3);
    supplyBelow = 1'b0;
    cyc(2);
    check(supplyLowFlag, 1'b0);
    supplyBelow = 1'b1;
    cyc(6);
    check(supplyLowFlag, 1'b1);
    supplyBelow = 1'b0;
    cyc(2);
    check(supplyLowFlag, 1'b0);
  endtask : t_supply
  task automatic t_power;
    hm.access(flash_pwr_pkg::OFS_BANK_SEL, 1'b1, 1'b1, 32'h0000_0000, q);
    hm.access(flash_pwr_pkg::OFS_BANK_AC1, 1'b1, 1'b1, 32'h0000_0500, q);
    bankAccess = 4'h1;
    cyc(30);
    check(bankReady[0], 1'b1);
    bankAccess = 4'h0;
    cyc(30);
    check(bankReady[0], 1'b0);
    check(bankReady[1], 1'b1);
    check(pumpActive, 1'b1);
    hm.access(flash_pwr_pkg::OFS_STATUS, 1'b0, 1'b1, '0, q);
    check(q, 32'h0000_02E0);
    pumpCmd = 1'b1;
    cyc(2);
    pumpCmd = 1'b0;
    check(pumpActive, 1'b1);
    hm.access(flash_pwr_pkg::OFS_PUMP_CFG, 1'b1, 1'b0, 32'h0000_0434, q);
    for (int b = 1; b < 4; b++) begin
      hm.access(flash_pwr_pkg::OFS_BANK_SEL, 1'b1, 1'b1, 32'(b), q);
      hm.access(flash_pwr_pkg::OFS_BANK_AC1, 1'b1, 1'b1, 32'h0000_0000, q);
    end
    cyc(10);
    check(pumpActive, 1'b0);
    check(bankReady, 4'h0);
    pumpCmd = 1'b1;
    cyc(3);
    check(pumpActive, 1'b0);
    cyc(4);
    check(pumpActive, 1'b1);
    pumpCmd = 1'b0;
    cyc(2);
    check(pumpActive, 1'b1);
    cyc(8);
    check(pumpActive, 1'b0);
    readReq    = 1'b1;
    bankAccess = 4'h1;
    cyc(2);
    check(readReady, 1'b0);
    for (int i = 0; i < 200 && readReady !== 1'b1; i++) cyc(1);
    check(readReady, 1'b1);
    check(bankReady[0], 1'b1);
    readReq    = 1'b0;
    bankAccess = 4'h0;
  endtask : t_power
  initial begin
    n_mismatch = 0;
    n_tests    = 0;
    {rst_b, haltMode, supplyBelow, pumpCmd, readReq} = '0;
    configMode = 1'b1;
    bankAccess = 4'h0;
    readBank   = 2'h0;
    cyc(3);
    rst_b = 1'b1;
    cyc(2);
    t_reset();
    t_option();
    t_refuse();
    t_pipe();
    t_supply();
    t_power();
    print_verdict();
  end
  initial begin
    #2_000_000;
    n_mismatch++;
    print_verdict();
  end
endmodule : flash_power_wait_control_tb

//--- verif/host_model.sv
// host_model: processor side of the register port
// assumes one strobe per access, read data valid the cycle after it
module host_model (
  // clock
  input  wire logic        ref_clk,
  // register port
  output logic             regSel,
  output logic             regWr,
  output logic             regWord,
  output logic [3:0]       regAddr,
  output logic [31:0]      regWdata,
  input  wire logic [31:0] regRdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {regSel, regWr, regWord, regAddr, regWdata} = '0;
  end
  // one-cycle strobe, answer taken one cycle later
  task automatic access(input logic [3:0] a, input logic w, input logic wd,
                        input logic [31:0] d, output logic [31:0] q);
    @(negedge ref_clk);
    regSel   = 1'b1;
    regWr    = w;
    regWord  = wd;
    regAddr  = a;
    regWdata = d;
    @(negedge ref_clk);
    regSel   = 1'b0;
    regWdata = ~d;
    q        = regRdata;
  endtask : access
endmodule : host_model
